// ==== design/afe_adc_mode_clock_channel_control.sv ====
// Mode, clock routing, channel and serial readout control for the front end
`timescale 1ns/10ps
module afe_adc_mode_clock_channel_control
  import afe_ctrl_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic DIN_I,
  output logic DOUT_O,
  output logic DOUT_OE_O,
  input wire logic CLK_PIN_I,
  output logic CLK_PIN_O,
  output logic CLK_PIN_OE_O,
  output logic ADC_CLK_O,
  output logic FE_CLK_O,
  input wire logic CONV_TOGGLE_I,
  input wire logic [1:0] CONV_CHAN_I,
  input wire logic [23:0] CONV_DATA_I,
  output logic CONV_READY_O,
  input wire logic [7:0] NV_COUNT_I,
  output logic NV_WRITE_O,
  output logic [7:0] NV_COUNT_O,
  output fe_ctrl_type FE_CTRL_O,
  output logic [2:0] CONV_MODE_O,
  output logic [3:0] CHAN_EN_O,
  output logic [3:0][15:0] FILTER_O
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  // Idle-high pins enter inverted, so the reset value matches idle and no false edge follows
  logic [SYNC_W-1:0] sync_s;
  logic sclk_q, tog_q;
  level_sync #(.W(SYNC_W)) u_sync (
    .clk_i(CORE_CLK_I),
    .arst_n_i(ARST_N_I),
    .d_i({CONV_TOGGLE_I, CLK_PIN_I, DIN_I, ~CS_N_I, ~SCLK_I}),
    .q_o(sync_s)
  );
  wire sclk_s = ~sync_s[0];
  wire cs_act = sync_s[1];
  wire din_s = sync_s[2];
  wire pin_s = sync_s[3];
  wire tog_s = sync_s[4];
  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire conv_evt = tog_s ^ tog_q;

  ////////////////////////////////////////////////////////////////////////
  // Serial frame engine
  spi_state_type state_q;
  logic [4:0] cnt_q;
  logic [15:0] sh_in_q;
  logic [3:0] addr_q;
  logic [23:0] rd_sh_q;
  logic bit_q, pin_q, oe_q;
  logic [23:0] rd_word;
  wire [3:0] cmd_addr = {sh_in_q[2:0], din_s};
  wire cmd_done = sclk_rise && state_q == S_CMD && cnt_q == CMD_LAST;
  wire cmd_read = sh_in_q[CMD_READ_BIT-1];
  wire [4:0] rd_last = (addr_q == ADDR_DATA) ? DATA_LAST : REG_LAST;
  wire wr_stb = sclk_rise && state_q == S_WR && cnt_q == REG_LAST;
  wire [15:0] wr_data = {sh_in_q[14:0], din_s};
  wire rd_done = sclk_rise && state_q == S_RD && cnt_q == rd_last;
  wire data_busy = state_q == S_RD && addr_q == ADDR_DATA;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return wr_stb && a == r;
  endfunction

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sclk_q <= 1'b1;
      tog_q <= 1'b0;
      state_q <= S_CMD;
      cnt_q <= '0;
      sh_in_q <= '0;
      addr_q <= '0;
      rd_sh_q <= '0;
      bit_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      tog_q <= tog_s;
      if (!cs_act) begin
        state_q <= S_CMD;
        cnt_q <= '0;
      end else if (sclk_rise) begin
        sh_in_q <= wr_data;
        cnt_q <= cnt_q + 5'h01;
        if (cmd_done) begin
          addr_q <= cmd_addr;
          cnt_q <= '0;
          state_q <= cmd_read ? S_RD : S_WR;
          rd_sh_q <= rd_word;
        end else if (wr_stb || rd_done) begin
          cnt_q <= '0;
          state_q <= S_CMD;
        end
      end else if (sclk_fall && state_q == S_RD) begin
        bit_q <= rd_sh_q[23];
        rd_sh_q <= {rd_sh_q[22:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [15:0] mode_q, fe_clk_q, cfg_q;
  fe_ctrl_type fe_q;
  logic [3:0][15:0] filt_q;
  logic loaded_q, nv_wr_q;
  logic [7:0] count_q, shown_q;
  wire [3:0] chan_en = {cfg_q[CFG_CHAN_LSB+2:CFG_CHAN_LSB], 1'b1};
  wire [7:0] nv_clamped = (NV_COUNT_I > CHANGE_LIMIT) ? CHANGE_LIMIT : NV_COUNT_I;
  // Stored mode is the parity of the remaining count, so a change flips it
  wire stored_mode = count_q[0];
  // Strobe named here too, so the assignment wakes when the strobe moves
  wire commit_req = wr_stb && hit(addr_q, ADDR_COMMIT) && wr_data == KEY_COMMIT;
  wire commit_ok = commit_req && count_q != 8'h00
    && fe_q.current_mode_select != stored_mode;
  wire refresh_req = wr_stb && hit(addr_q, ADDR_COMMIT) && wr_data == KEY_REFRESH;

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mode_q <= MODE_RST;
      fe_clk_q <= FE_CLK_RST;
      cfg_q <= CONFIG_RST;
      fe_q <= FE_CTRL2_RST;
      loaded_q <= 1'b0;
      count_q <= '0;
      shown_q <= '0;
      nv_wr_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
      nv_wr_q <= commit_ok;
      if (!loaded_q) begin
        count_q <= nv_clamped;
        shown_q <= nv_clamped;
        fe_q.current_mode_select <= nv_clamped[0];
      end else begin
        if (hit(addr_q, ADDR_MODE)) mode_q <= wr_data;
        if (hit(addr_q, ADDR_FE_CLK)) fe_clk_q <= wr_data;
        if (hit(addr_q, ADDR_CONFIG)) cfg_q <= wr_data;
        if (hit(addr_q, ADDR_FE_CTRL2)) fe_q <= wr_data;
        if (commit_ok) count_q <= count_q - 8'h01;
        if (refresh_req) shown_q <= count_q;
      end
    end
  end

  // Only enabled channels take a shared filter write
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
          filt_q[g] <= FILTER_RST;
        end else if (hit(addr_q, ADDR_FILTER) && chan_en[g]) begin
          filt_q[g] <= wr_data;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Clock routing
  logic osc_q, adc_clk_q, fe_clk_out_q, clk_oe_q;
  wire [1:0] adc_sel = mode_q[MODE_CLK_LSB+1:MODE_CLK_LSB];
  wire [1:0] fe_sel = fe_clk_q[FE_CLK_LSB+1:FE_CLK_LSB];
  // Internal oscillator stand-in; the real one is analog and not modelled here
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      osc_q <= 1'b0;
      adc_clk_q <= 1'b0;
      fe_clk_out_q <= 1'b0;
      clk_oe_q <= 1'b0;
    end else begin
      osc_q <= ~osc_q;
      clk_oe_q <= adc_sel == CLK_DRIVE_OUT;
      adc_clk_q <= (adc_sel == CLK_FROM_PIN) ? pin_s : osc_q;
      fe_clk_out_q <= (fe_sel == CLK_FROM_PIN) ? pin_s : osc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion path
  conv_word_type push_word, head_word, data_q;
  logic buf_valid, ready_n_q;
  wire unipolar = cfg_q[CFG_UNIPOLAR_BIT];
  wire [23:0] uni_code = CONV_DATA_I[23] ? 24'h000000 : {CONV_DATA_I[22:0], 1'b0};
  wire [23:0] bi_code = {~CONV_DATA_I[23], CONV_DATA_I[22:0]};
  assign push_word = '{chan: CONV_CHAN_I, data: unipolar ? uni_code : bi_code};
  wire pop = buf_valid && !data_busy;
  wire push_ok = conv_evt && CONV_READY_O;

  conv_buffer #(.W($bits(conv_word_type)), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_i(CORE_CLK_I),
    .arst_n_i(ARST_N_I),
    .in_valid_i(conv_evt),
    .in_ready_o(CONV_READY_O),
    .in_data_i(push_word),
    .out_valid_o(buf_valid),
    .out_ready_i(!data_busy),
    .out_data_o(head_word)
  );

  // A new result wins over a read completing in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      data_q <= '0;
      ready_n_q <= 1'b1;
      pin_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      if (pop) begin
        data_q <= head_word;
        ready_n_q <= 1'b0;
      end else if (rd_done && addr_q == ADDR_DATA) begin
        ready_n_q <= 1'b1;
      end
      oe_q <= cs_act;
      pin_q <= (state_q == S_RD) ? bit_q : ready_n_q;
    end
  end

  always_comb begin
    unique case (cmd_addr)
      ADDR_MODE: rd_word = {mode_q, 8'h00};
      ADDR_FE_CTRL2: rd_word = {fe_q, 8'h00};
      ADDR_FE_CLK: rd_word = {fe_clk_q, 8'h00};
      ADDR_CONFIG: rd_word = {cfg_q, 8'h00};
      ADDR_FILTER: rd_word = {filt_q[0], 8'h00};
      ADDR_DATA: rd_word = data_q.data;
      ADDR_CONV_STAT: rd_word = {ready_n_q, 13'h0000, data_q.chan, 8'h00};
      ADDR_DEF_COUNT: rd_word = {8'h00, shown_q, 8'h00};
      default: rd_word = 24'h000000;
    endcase
  end

  assign DOUT_O = pin_q;
  assign DOUT_OE_O = oe_q;
  assign CLK_PIN_O = osc_q;
  assign CLK_PIN_OE_O = clk_oe_q;
  assign ADC_CLK_O = adc_clk_q;
  assign FE_CLK_O = fe_clk_out_q;
  assign NV_WRITE_O = nv_wr_q;
  assign NV_COUNT_O = count_q;
  assign FE_CTRL_O = fe_q;
  assign CONV_MODE_O = mode_q[MODE_CONV_LSB+2:MODE_CONV_LSB];
  assign CHAN_EN_O = chan_en;
  assign FILTER_O = filt_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_commit;
    commit_ok && loaded_q;
  endsequence
  property p_commit_dec;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      s_commit |=> (count_q == $past(count_q) - 8'h01 && NV_WRITE_O && NV_COUNT_O == count_q)
        ##1 !NV_WRITE_O;
  endproperty
  a_commit_dec: assert property (p_commit_dec) else $error("commit count wrong");
  property p_zero_hold;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      loaded_q && count_q == 8'h00 |=> count_q == 8'h00 && !NV_WRITE_O;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("commit at zero");
  property p_refresh;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      loaded_q && refresh_req |=> shown_q == $past(count_q);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh not loaded");
  property p_clk_out;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      (adc_sel == CLK_DRIVE_OUT) [*2] |-> CLK_PIN_OE_O;
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("pin not driven");
  property p_clk_ext;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      adc_sel == CLK_FROM_PIN |=> ADC_CLK_O == $past(pin_s) && !CLK_PIN_OE_O;
  endproperty
  a_clk_ext: assert property (p_clk_ext) else $error("ext clock not used");
  property p_fe_pin;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      fe_sel == CLK_FROM_PIN |=> FE_CLK_O == $past(pin_s);
  endproperty
  a_fe_pin: assert property (p_fe_pin) else $error("front-end clock not from pin");
  property p_oe_idle;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      CS_N_I [*3] |=> !DOUT_OE_O;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pin driven while deselected");
  property p_unipolar;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      push_ok && unipolar && CONV_DATA_I[23] |-> push_word.data == 24'h000000;
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("negative not zero");
  property p_filter;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      hit(addr_q, ADDR_FILTER) && !chan_en[3] |=> $stable(filt_q[3]);
  endproperty
  a_filter: assert property (p_filter) else $error("disabled filter changed");
  property p_ready;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      pop |=> !ready_n_q ##1 (state_q == S_RD || !DOUT_O);
  endproperty
  a_ready: assert property (p_ready) else $error("ready not low");
  property p_read_done;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      rd_done && addr_q == ADDR_DATA && !pop |=> ready_n_q;
  endproperty
  a_read_done: assert property (p_read_done) else $error("ready not raised");
  property p_no_update;
    @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
      data_busy |=> $stable(data_q);
  endproperty
  a_no_update: assert property (p_no_update) else $error("data changed in read");
endmodule // afe_adc_mode_clock_channel_control

// ==== design/afe_ctrl_pkg.sv ====
// Shared constants and types for the front-end mode, clock and channel control block
package afe_ctrl_pkg;
  // Register addresses (4-bit serial address field)
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_FE_CTRL2 = 4'h4;
  localparam logic [3:0] ADDR_FE_CLK = 4'h8;
  localparam logic [3:0] ADDR_CONFIG = 4'h9;
  localparam logic [3:0] ADDR_FILTER = 4'hA;
  localparam logic [3:0] ADDR_DATA = 4'hB;
  localparam logic [3:0] ADDR_CONV_STAT = 4'hC;
  localparam logic [3:0] ADDR_COMMIT = 4'hE;
  localparam logic [3:0] ADDR_DEF_COUNT = 4'hF;
  // Key values for the default-select register
  localparam logic [15:0] KEY_COMMIT = 16'h00B1;
  localparam logic [15:0] KEY_REFRESH = 16'h00A1;
  localparam logic [7:0] CHANGE_LIMIT = 8'h64;
  // Field positions
  localparam int CMD_READ_BIT = 6;
  localparam int MODE_CLK_LSB = 2;
  localparam int MODE_CONV_LSB = 4;
  localparam int FE_CLK_LSB = 3;
  localparam int CFG_UNIPOLAR_BIT = 0;
  localparam int CFG_CHAN_LSB = 1;
  // Clock routing codes
  localparam logic [1:0] CLK_DRIVE_OUT = 2'h1;
  localparam logic [1:0] CLK_FROM_PIN = 2'h2;
  // Reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] FE_CLK_RST = 16'h0000;
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [15:0] FILTER_RST = 16'h0000;
  localparam logic [15:0] FE_CTRL2_RST = 16'h0000;
  // Serial frame lengths, in bits less one
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] REG_LAST = 5'h0F;
  localparam logic [4:0] DATA_LAST = 5'h17;
  localparam int SYNC_W = 5;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [3:0] neg_pulls;
    logic [3:0] pos_pulls;
    logic [1:0] bias_generator_control;
    logic [1:0] rsvd_hi;
    logic field_power_enable;
    logic external_sense_select;
    logic current_mode_select;
    logic rsvd_lo;
  } fe_ctrl_type;

  typedef struct packed {
    logic [1:0] chan;
    logic [23:0] data;
  } conv_word_type;

  typedef enum logic [1:0] {S_CMD, S_WR, S_RD} spi_state_type;
endpackage

// ==== design/level_sync.sv ====
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module level_sync #(parameter int W = 1) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          meta_q[g] <= 1'b0;
          q_o[g] <= 1'b0;
        end else begin
          meta_q[g] <= d_i[g];
          q_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule // level_sync

// ==== design/conv_buffer.sv ====
// Small valid/ready buffer for conversion words
`timescale 1ns/10ps
module conv_buffer #(parameter int W = 26, parameter int DEPTH = 2) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] lvl_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (lvl_q != (AW+1)'(DEPTH));
  assign out_valid_o = (lvl_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      lvl_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + AW'(1);
      end
      lvl_q <= lvl_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // conv_buffer

// ==== verif/conv_nv_model.sv ====
// Converter result source and nonvolatile change-count store beside the block
`timescale 1ns/10ps
module conv_nv_model (
  input wire logic clk_i,
  input wire logic nv_write_i,
  input wire logic [7:0] nv_count_i,
  output logic toggle_o,
  output logic [1:0] chan_o,
  output logic [23:0] data_o,
  output logic [7:0] stored_o
);
  int n_writes = 0;
  initial begin
    toggle_o = 1'b0;
    chan_o = 2'h0;
    data_o = 24'h000000;
    stored_o = 8'h05;
  end
  ////////////////////////////////////////
  // Store survives resets like flash, so power-up sees the last commit
  always @(posedge clk_i) begin
    if (nv_write_i) begin
      stored_o <= nv_count_i;
      n_writes <= n_writes + 1;
    end
  end
  ////////////////////////////////////////
  // Word held 8 cycles, then scrambled so a late capture shows
  task automatic push(input logic [1:0] ch, input logic [23:0] d);
    @(posedge clk_i);
    #1;
    chan_o = ch;
    data_o = d;
    toggle_o = ~toggle_o;
    repeat (8) @(posedge clk_i);
    #1;
    chan_o = ~ch;
    data_o = ~d;
  endtask
endmodule // conv_nv_model

// ==== verif/afe_adc_mode_clock_channel_control_bench.sv ====
// Self-checking bench for the mode, clock and channel control block
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module afe_adc_mode_clock_channel_control_bench;
  import afe_ctrl_pkg::*;
  logic clk, arst_n, sclk, cs_n, din, clk_pin, a0;
  logic dout, dout_oe, pin_o, pin_oe, adc_clk, fe_clk, conv_rdy, nv_wr, tog;
  logic [1:0] chan;
  logic [23:0] cdata, rd;
  logic [7:0] nv_in, nv_out;
  fe_ctrl_type fe;
  logic [2:0] cmode;
  logic [3:0] chan_en;
  logic [3:0][15:0] filt;
  // Pin pulled up while the block does not drive it
  wire dout_w = dout_oe ? dout : 1'b1;
  int num_errors = 0;
  int n_tests = 0;

  afe_adc_mode_clock_channel_control dut_u (.CORE_CLK_I(clk), .ARST_N_I(arst_n),
    .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .DOUT_O(dout), .DOUT_OE_O(dout_oe),
    .CLK_PIN_I(clk_pin), .CLK_PIN_O(pin_o), .CLK_PIN_OE_O(pin_oe), .ADC_CLK_O(adc_clk),
    .FE_CLK_O(fe_clk), .CONV_TOGGLE_I(tog), .CONV_CHAN_I(chan), .CONV_DATA_I(cdata),
    .CONV_READY_O(conv_rdy), .NV_COUNT_I(nv_in), .NV_WRITE_O(nv_wr), .NV_COUNT_O(nv_out),
    .FE_CTRL_O(fe), .CONV_MODE_O(cmode), .CHAN_EN_O(chan_en), .FILTER_O(filt));
  conv_nv_model nvm_u (.clk_i(clk), .nv_write_i(nv_wr), .nv_count_i(nv_out),
    .toggle_o(tog), .chan_o(chan), .data_o(cdata), .stored_o(nv_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    tick(6);
    arst_n = 1'b1;
    tick(4);
  endtask
  // Serial clock runs only inside a frame; read bits taken as the clock rises
  task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int nb,
                       output logic [23:0] rv);
    logic [31:0] sh;
    sh = {cmd, wd};
    rv = 24'h000000;
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < 8 + nb; i++) begin
      sclk = 1'b0;
      din = sh[31 - i];
      tick(4);
      if (i >= 8) rv = {rv[22:0], dout_w};
      sclk = 1'b1;
      tick(4);
    end
    tick(4);
    cs_n = 1'b1;
    tick(6);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    frame({4'h0, a}, {v, 8'h00}, 16, rd);
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
    frame({4'h4, a}, 24'h000000, 16, rd);
    `CHK(rd[15:0], e)
  endtask
  task automatic rdata(input logic [23:0] e);
    frame({4'h4, ADDR_DATA}, 24'h000000, 24, rd);
    `CHK(rd, e)
  endtask
  task automatic follow(input logic sel);
    for (int k = 0; k < 4; k++) begin
      clk_pin = k[0];
      tick(6);
      `CHK(sel ? adc_clk : fe_clk, k[0])
      tick(1);
      `CHK(sel ? adc_clk : fe_clk, k[0])
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    arst_n = 1'b0;
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
    clk_pin = 1'b0;
    do_reset();
    `CHK(fe.current_mode_select, 1'b1)
    `CHK(fe.bias_generator_control, 2'h0)
    `CHK({pin_oe, cmode, chan_en}, 8'h01)
    a0 = fe_clk;
    tick(1);
    `CHK(fe_clk, ~a0)
    chk_reg(ADDR_DEF_COUNT, 16'h0005);
    chk_reg(ADDR_FE_CTRL2, 16'h0002);
    wr(ADDR_FE_CTRL2, 16'h5ACC);
    `CHK(fe, 16'h5ACC)
    chk_reg(ADDR_FE_CTRL2, 16'h5ACC);
    wr(ADDR_COMMIT, KEY_COMMIT);
    `CHK(nv_in, 8'h04)
    `CHK(nv_out, 8'h04)
    wr(ADDR_COMMIT, KEY_REFRESH);
    chk_reg(ADDR_DEF_COUNT, 16'h0004);
    wr(ADDR_COMMIT, KEY_COMMIT);
    `CHK(nvm_u.n_writes, 1)
    do_reset();
    `CHK(fe.current_mode_select, 1'b0)
    // Exhausted count refuses a commit that would change the mode
    nvm_u.stored_o = 8'h00;
    do_reset();
    wr(ADDR_FE_CTRL2, 16'h0002);
    wr(ADDR_COMMIT, KEY_COMMIT);
    `CHK(nvm_u.n_writes, 1)
    wr(ADDR_COMMIT, KEY_REFRESH);
    chk_reg(ADDR_DEF_COUNT, 16'h0000);
    nvm_u.stored_o = 8'hC8;
    do_reset();
    chk_reg(ADDR_DEF_COUNT, 16'h0064);
    wr(ADDR_DEF_COUNT, 16'h0033);
    chk_reg(ADDR_DEF_COUNT, 16'h0064);
    chk_reg(4'h3, 16'h0000);
    ////////////////////////////////////////
    wr(ADDR_MODE, 16'h0004);
    `CHK(pin_oe, 1'b1)
    a0 = pin_o;
    tick(1);
    `CHK(pin_o, ~a0)
    wr(ADDR_FE_CLK, 16'h0010);
    follow(1'b0);
    wr(ADDR_MODE, 16'h0008);
    `CHK(pin_oe, 1'b0)
    follow(1'b1);
    ////////////////////////////////////////
    wr(ADDR_CONFIG, 16'h000A);
    `CHK(chan_en, 4'hB)
    wr(ADDR_FILTER, 16'h1234);
    `CHK(filt, 64'h1234_0000_1234_1234)
    wr(ADDR_CONFIG, 16'h0004);
    wr(ADDR_FILTER, 16'h0BCD);
    `CHK(filt, 64'h1234_0BCD_1234_0BCD)
    ////////////////////////////////////////
    cs_n = 1'b0;
    nvm_u.push(2'h3, 24'h800001);
    tick(4);
    `CHK(dout_w, 1'b0)
    cs_n = 1'b1;
    tick(6);
    chk_reg(ADDR_CONV_STAT, 16'h0003);
    rdata(24'h000001);
    chk_reg(ADDR_CONV_STAT, 16'h8003);
    rdata(24'h000001);
    // Results during a read wait in the buffer; a third one is lost
    fork
      rdata(24'h000001);
      begin
        tick(90);
        nvm_u.push(2'h1, 24'h000010);
        nvm_u.push(2'h2, 24'h000020);
        `CHK(conv_rdy, 1'b0)
        nvm_u.push(2'h3, 24'h000030);
      end
    join
    tick(10);
    `CHK(conv_rdy, 1'b1)
    chk_reg(ADDR_CONV_STAT, 16'h0002);
    rdata(24'h800020);
    wr(ADDR_CONFIG, 16'h0001);
    nvm_u.push(2'h0, 24'hFFFFF0);
    rdata(24'h000000);
    nvm_u.push(2'h0, 24'h001234);
    rdata(24'h002468);
    wrap_up();
  end
endmodule // afe_adc_mode_clock_channel_control_bench
